/* File: sim/sbc_regs_checker.sv */
`timescale 1ns/1ps
module sbc_regs_checker (
  input wire logic mclk,
  input wire logic sys_rst,
  input wire logic restart_evt,
  input wire logic wake_sources_enabled,
  input wire logic [1:0] chip_state,
  input wire logic aux_supply_en,
  input wire logic [1:0] main_supply_undervoltage_threshold,
  input wire logic undervoltage_reset_en,
  input wire logic soft_reset_pulse
);
  default clocking @(posedge mclk); endclocking
  default disable iff (sys_rst);
  property p_po; $fell(sys_rst) |-> chip_state == 2'h0 && undervoltage_reset_en; endproperty
  a_po: assert property (p_po) else $error("reset");
  property p_st; chip_state != 2'h3; endproperty
  a_st: assert property (p_st) else $error("code");
  property p_sp; soft_reset_pulse |=> !soft_reset_pulse; endproperty
  a_sp: assert property (p_sp) else $error("pulse");
  property p_sn; soft_reset_pulse |-> ##[1:2] chip_state == 2'h0; endproperty
  a_sn: assert property (p_sn) else $error("soft");
  property p_uv;
    undervoltage_reset_en == (main_supply_undervoltage_threshold != 2'h3);
  endproperty
  a_uv: assert property (p_uv) else $error("uv");
  property p_rc; restart_evt |-> ##[1:3] chip_state == 2'h0 && !aux_supply_en; endproperty
  a_rc: assert property (p_rc) else $error("clear");
  property p_rk; $rose(restart_evt) |=> $stable(main_supply_undervoltage_threshold); endproperty
  a_rk: assert property (p_rk) else $error("keep");
  property p_sl;
    chip_state == 2'h1 && $past(chip_state) != 2'h1 |-> $past(wake_sources_enabled);
  endproperty
  a_sl: assert property (p_sl) else $error("sleep");
  c_sl: cover property (chip_state == 2'h1);
  c_sr: cover property (soft_reset_pulse);
  c_rs: cover property (restart_evt);
endmodule
bind sbc_mode_supply_regs sbc_regs_checker chk_u (.*);

/* File: sim/spi_master_model.sv */
`timescale 1ns/1ps
module spi_master_model (
  input wire logic mclk,
  input wire logic miso,
  output logic cs_n,
  output logic sclk_rise,
  output logic mosi
);
  initial {cs_n, sclk_rise, mosi} = 3'h4;
  // The line is inverted after release so that stale data is never mistaken for a drive.
  task automatic xfer(input logic [15:0] f, output logic [7:0] rx);
    @(negedge mclk) cs_n = 1'b0;
    for (int i = 0; i < 16; i++) begin
      @(negedge mclk) mosi = f[i];
      sclk_rise = 1'b1;
      if (i > 7) rx[i-8] = miso;
      @(negedge mclk) sclk_rise = 1'b0;
    end
    @(negedge mclk) cs_n = 1'b1;
    mosi = ~mosi;
  endtask
endmodule

/* File: sim/tb.sv */
`timescale 1ns/1ps
module tb;
  logic mclk = 1'b0;
  logic sys_rst = 1'b1;
  logic restart_evt = 1'b0;
  logic main_overvoltage = 1'b0;
  logic wake_sources_enabled = 1'b0;
  logic [7:0] regulator_status = 8'ha5;
  logic cs_n, sclk_rise, mosi, miso, aux_supply_en, undervoltage_reset_en, restart_req;
  logic soft_reset_pulse;
  logic [1:0] chip_state, main_supply_undervoltage_threshold;
  logic [7:0] rx;
  int err_count = 0;
  int n_tests = 0;
  int seen = 0;
  always #2.5 mclk = ~mclk;
  always @(posedge mclk) if (restart_req === 1'b1) seen++;
  // The family code is an arbitrary value.
  sbc_mode_supply_regs #(.family_product_code(8'h3c)) dut_u (.*, .miso_q());
  spi_master_model mm (.*);
  task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    n_tests++;
    if (g !== e) begin
      err_count++;
      $display("BAD %s exp %h got %h", nm, e, g);
    end
  endtask
  task automatic acc(input logic [6:0] a, input logic [7:0] d, input logic w = 1'b1);
    mm.xfer({d, w, a}, rx);
    repeat (3) @(negedge mclk);
  endtask
  task automatic rd(input logic [6:0] a, input logic [7:0] e);
    acc(a, 8'h00, 1'b0);
    chk("rd", e, rx);
  endtask
  task automatic ovp(input logic [7:0] e);
    seen = 0;
    main_overvoltage = 1'b1;
    @(negedge mclk) main_overvoltage = 1'b0;
    repeat (3) @(negedge mclk);
    chk("ov", e, seen > 0);
  endtask
  task automatic summarize;
    $display("checks %0d mismatches %0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  initial begin
    repeat (20) @(negedge mclk);
    sys_rst = 1'b0;
    rd(7'h01, 8'h00);
    rd(7'h1f, 8'h3c);
    rd(7'h13, 8'ha5);
    rd(7'h05, 8'h00);
    acc(7'h1f, 8'h00);
    rd(7'h1f, 8'h3c);
    acc(7'h01, 8'h3f);
    rd(7'h01, 8'h1f);
    acc(7'h01, 8'h9a);
    chk("st", 8'h02, chip_state);
    chk("thr", 8'h02, main_supply_undervoltage_threshold);
    chk("aux", 8'h01, aux_supply_en);
    restart_evt = 1'b1;
    @(negedge mclk) restart_evt = 1'b0;
    rd(7'h01, 8'h02);
    acc(7'h01, 8'h44);
    chk("st", 8'h00, chip_state);
    chk("req", 8'h01, seen > 0);
    acc(7'h01, 8'h04);
    ovp(8'h01);
    acc(7'h01, 8'h00);
    ovp(8'h00);
    wake_sources_enabled = 1'b1;
    acc(7'h01, 8'h58);
    chk("st", 8'h01, chip_state);
    chk("aux", 8'h01, aux_supply_en);
    acc(7'h01, 8'h48);
    chk("aux", 8'h00, aux_supply_en);
    acc(7'h01, 8'hdb);
    rd(7'h01, 8'h00);
    summarize();
  end
endmodule

/* File: verilog/frame_if.sv */
`timescale 1ns/1ps
interface frame_if;
  logic done;
  logic write;
  logic [6:0] addr;
  logic [7:0] wdata;
  logic [7:0] rdata;
  modport shifter (output done, output write, output addr, output wdata, input rdata);
  modport bank (input done, input write, input addr, input wdata, output rdata);
endinterface

/* File: verilog/frame_shifter.sv */
`timescale 1ns/1ps
// Shifts one 16-bit frame, LSB first, while select is active.
module frame_shifter (
  input wire logic mclk,
  input wire logic sys_rst,
  input wire logic cs_n,
  input wire logic sclk_rise,
  input wire logic mosi,
  output logic miso,
  frame_if.shifter fr
);
  logic [4:0] cnt_q;
  logic [15:0] sh_q;
  logic [7:0] out_q;
  logic last;
  logic [15:0] sh_d;
  assign last = (cnt_q == sbc_regs_pkg::bit_count_last);
  assign sh_d = {mosi, sh_q[15:1]};
  assign miso = out_q[0];
  always_ff @(posedge mclk) begin
    fr.done <= 1'b0;
    if (sys_rst || cs_n) begin
      cnt_q <= 5'h00;
      sh_q <= 16'h0000;
      out_q <= 8'h00;
      if (sys_rst) begin
        fr.write <= 1'b0;
        fr.addr <= 7'h00;
        fr.wdata <= 8'h00;
      end
    end else if (sclk_rise) begin
      sh_q <= sh_d;
      cnt_q <= last ? 5'h00 : cnt_q + 5'h01;
      // The address is taken one bit early so the read mux has settled by the load below.
      if (cnt_q == 5'h06) begin
        fr.addr <= sh_d[15:9];
      end
      if (cnt_q == 5'h07) begin
        out_q <= fr.rdata;
      end else begin
        out_q <= {1'b0, out_q[7:1]};
      end
      if (last) begin
        fr.done <= 1'b1;
        fr.write <= sh_d[sbc_regs_pkg::access_bit_pos];
        fr.addr <= sh_d[6:0];
        fr.wdata <= sh_d[15:8];
      end
    end
  end
endmodule

/* File: verilog/sbc_mode_supply_regs.sv */
`timescale 1ns/1ps
module sbc_mode_supply_regs #(
  parameter logic [7:0] family_product_code = 8'h5a
) (
  input wire logic mclk,
  input wire logic sys_rst,
  input wire logic cs_n,
  input wire logic sclk_rise,
  input wire logic mosi,
  output logic miso,
  input wire logic restart_evt,
  input wire logic main_overvoltage,
  input wire logic wake_sources_enabled,
  input wire logic [7:0] regulator_status,
  output logic [1:0] chip_state,
  output logic aux_supply_en,
  output logic [1:0] main_supply_undervoltage_threshold,
  output logic undervoltage_reset_en,
  output logic restart_req,
  output logic soft_reset_pulse,
  output logic miso_q
);
  frame_if fr ();
  logic [7:0] ctrl_q;
  logic [7:0] ctrl_d;
  logic [7:0] rd_sel;
  logic wr_ctrl;
  logic [1:0] req_mode;
  logic sleep_bad;
  logic ov_rst;
  logic aux_d;
  sbc_regs_pkg::chip_state_t st_q;
  sbc_regs_pkg::chip_state_t st_d;

  frame_shifter u_shift (
    .mclk(mclk),
    .sys_rst(sys_rst),
    .cs_n(cs_n),
    .sclk_rise(sclk_rise),
    .mosi(mosi),
    .miso(miso),
    .fr(fr)
  );

  // Reserved bit 5 is masked out on write so it always reads zero.
  assign rd_sel = (fr.addr == sbc_regs_pkg::addr_mode_supply) ? ctrl_q :
                  (fr.addr == sbc_regs_pkg::addr_regulator_status) ? regulator_status :
                  (fr.addr == sbc_regs_pkg::addr_family_product) ? family_product_code :
                  8'h00;
  assign fr.rdata = rd_sel;
  assign wr_ctrl = fr.done && fr.write && (fr.addr == sbc_regs_pkg::addr_mode_supply);
  assign req_mode = fr.wdata[sbc_regs_pkg::mode_lsb +: 2];
  assign sleep_bad = wr_ctrl && (req_mode == sbc_regs_pkg::mode_sleep)
                     && !wake_sources_enabled;
  assign ov_rst = main_overvoltage && ctrl_q[sbc_regs_pkg::ov_bit];

  // A serial write changes the register, and a restart (restart_evt, sleep_bad or ov_rst) clears all but bits 2 to 0.
  always_comb begin
    ctrl_d = ctrl_q;
    if (restart_evt || sleep_bad || ov_rst) begin
      ctrl_d = ctrl_q & sbc_regs_pkg::mode_supply_keep_on_restart;
    end else if (wr_ctrl) begin
      ctrl_d = fr.wdata & sbc_regs_pkg::mode_supply_writable;
      if (req_mode == sbc_regs_pkg::mode_soft_reset) begin
        ctrl_d = sbc_regs_pkg::mode_supply_reset;
      end
    end
  end

  always_comb begin
    st_d = st_q;
    if (restart_evt || sleep_bad || ov_rst) begin
      st_d = sbc_regs_pkg::st_restart;
    end else if (wr_ctrl) begin
      unique case (req_mode)
        sbc_regs_pkg::mode_normal: st_d = sbc_regs_pkg::st_normal;
        sbc_regs_pkg::mode_sleep: st_d = sbc_regs_pkg::st_sleep;
        sbc_regs_pkg::mode_stop: st_d = sbc_regs_pkg::st_stop;
        sbc_regs_pkg::mode_soft_reset: st_d = sbc_regs_pkg::st_normal;
      endcase
    end
  end

  always_comb begin
    unique case (ctrl_d[sbc_regs_pkg::aux_lsb +: 2])
      2'h0: aux_d = 1'b0;
      2'h1: aux_d = (st_d == sbc_regs_pkg::st_normal);
      2'h2: aux_d = (st_d == sbc_regs_pkg::st_normal) || (st_d == sbc_regs_pkg::st_stop);
      2'h3: aux_d = (st_d != sbc_regs_pkg::st_restart);
    endcase
  end

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      ctrl_q <= sbc_regs_pkg::mode_supply_reset;
      st_q <= sbc_regs_pkg::st_normal;
      chip_state <= sbc_regs_pkg::mode_normal;
      aux_supply_en <= 1'b0;
      main_supply_undervoltage_threshold <= 2'h0;
      undervoltage_reset_en <= 1'b1;
      restart_req <= 1'b0;
      soft_reset_pulse <= 1'b0;
      miso_q <= 1'b0;
    end else begin
      ctrl_q <= ctrl_d;
      st_q <= st_d;
      chip_state <= ctrl_d[sbc_regs_pkg::mode_lsb +: 2];
      aux_supply_en <= aux_d;
      main_supply_undervoltage_threshold <= ctrl_d[sbc_regs_pkg::uv_lsb +: 2];
      undervoltage_reset_en <= (ctrl_d[sbc_regs_pkg::uv_lsb +: 2] != 2'h3);
      restart_req <= sleep_bad || ov_rst;
      // Soft reset pulses only this line; the reset output pin stays quiet.
      soft_reset_pulse <= wr_ctrl && !sleep_bad && !ov_rst && !restart_evt
                          && (req_mode == sbc_regs_pkg::mode_soft_reset);
      miso_q <= miso;
    end
  end
endmodule

/* File: verilog/sbc_regs_pkg.sv */
// Notes on behaviour
// - Each access is one two-byte frame.
// - Command byte: seven address bits plus access bit.
// - Data byte sits in frame bits 8 to 15.
// - Power-on or soft reset loads default values.
// - Restart reloads, x bits keep old contents.
// - Bits are read-only, read-write, or hardware-modified.
// - Control bits change only by serial writes; the code also clears bits 7 to 3 on any restart.
// - Mode field: normal, sleep, stop, soft reset.
// - Bit five reserved, always reads zero.
// - Auxiliary supply field selects modes it runs.
// - Overvoltage reset enable moves chip to restart.
// - Undervoltage threshold select, code three disables.
// - Sleep without wake source forces restart.
// - Mode register: zero at reset, low three kept.
package sbc_regs_pkg;
  localparam int unsigned frame_bits = 16;
  localparam int unsigned addr_bits = 7;
  localparam int unsigned access_bit_pos = 7;
  localparam int unsigned data_lsb_pos = 8;
  localparam logic [6:0] addr_mode_supply = 7'h01;
  localparam logic [6:0] addr_regulator_status = 7'h13;
  localparam logic [6:0] addr_family_product = 7'h1f;
  localparam logic [7:0] mode_supply_reset = 8'h00;
  localparam logic [7:0] mode_supply_keep_on_restart = 8'h07;
  localparam logic [7:0] mode_supply_writable = 8'hdf;
  localparam int unsigned mode_lsb = 6;
  localparam int unsigned aux_lsb = 3;
  localparam int unsigned ov_bit = 2;
  localparam int unsigned uv_lsb = 0;
  localparam logic [4:0] bit_count_last = 5'h0f;
  typedef enum logic [1:0] {
    mode_normal = 2'h0,
    mode_sleep = 2'h1,
    mode_stop = 2'h2,
    mode_soft_reset = 2'h3
  } chip_mode_t;
  typedef enum logic [3:0] {
    st_normal = 4'h1,
    st_sleep = 4'h2,
    st_stop = 4'h4,
    st_restart = 4'h8
  } chip_state_t;
endpackage
